/* rtl/sggs_defs.svh */
`ifndef SGGS_DEFS_SVH
`define SGGS_DEFS_SVH

// timing
`define SGGS_CLK_NS 10
`define SGGS_MS_NS 1000000
`define SGGS_MS_CYCLES ((`SGGS_MS_NS) / (`SGGS_CLK_NS))

// switching modes
`define SGGS_MODE_FIX_A 3'h0
`define SGGS_MODE_FIX_B 3'h1
`define SGGS_MODE_DI 3'h2
`define SGGS_MODE_FREQ 3'h3
`define SGGS_MODE_DEV 3'h4
`define SGGS_MODE_SPEED 3'h5

// parameter defaults
`define SGGS_MODE_DEF 3'h0
`define SGGS_LEVEL_DEF 15'h0064
`define SGGS_HYST_DEF 15'h0005
`define SGGS_DELAY_DEF 12'h005
`define SGGS_BLEND_DEF 12'h005
`define SGGS_GAIN_A_DEF 16'h0064
`define SGGS_GAIN_B_DEF 16'h00C8

// register byte offsets
`define SGGS_OFS_MODE 8'h00
`define SGGS_OFS_LEVEL 8'h04
`define SGGS_OFS_HYST 8'h08
`define SGGS_OFS_DELAY 8'h0C
`define SGGS_OFS_BLEND 8'h10
`define SGGS_OFS_GAIN_A 8'h14
`define SGGS_OFS_GAIN_B 8'h24
`define SGGS_OFS_STATUS 8'h34
`define SGGS_WORD 8'h04

// status bit positions
`define SGGS_ST_GROUP 0
`define SGGS_ST_BLEND 1
`define SGGS_ST_PEND 2

// divider steps and gain count
`define SGGS_DIV_STEPS 5'h1C
`define SGGS_NGAIN 4

`endif

/* rtl/sggs_lerp.sv */
`timescale 1ns/1ps
`include "sggs_defs.svh"

module sggs_lerp (
    input wire logic clk_in, // control clock
    input wire logic rst_b_in, // async reset, low
    input wire logic hold_in, // follow target directly
    input wire logic load_in, // capture blend start
    input wire logic go_in, // recompute step
    input wire logic [15:0] target_in, // target gain
    input wire logic [11:0] elapsed_in, // ms into blend
    input wire logic [11:0] total_in, // blend length, ms
    output logic [15:0] value_out // interpolated gain
);
    logic [15:0] value_r;
    logic [15:0] start_r;
    logic [27:0] dvd_r;
    logic [12:0] rem_r;
    logic [15:0] quo_r;
    logic [4:0] cnt_r;
    logic fin_r;
    logic neg_r;
    wire neg = target_in < start_r;
    wire [15:0] mag = neg ? start_r - target_in : target_in - start_r;
    wire [27:0] prod = mag * elapsed_in;
    wire [12:0] rem_sh = {rem_r[11:0], dvd_r[27]};
    wire fits = rem_sh >= {1'b0, total_in};

    assign value_out = value_r;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            value_r <= 16'h0000;
            start_r <= 16'h0000;
            dvd_r <= 28'h0000000;
            rem_r <= 13'h0000;
            quo_r <= 16'h0000;
            cnt_r <= 5'h00;
            fin_r <= 1'b0;
            neg_r <= 1'b0;
        end else if (hold_in) begin
            value_r <= target_in;
            cnt_r <= 5'h00;
            fin_r <= 1'b0;
            if (load_in) begin
                start_r <= value_r;
            end
        end else if (go_in) begin
            if (elapsed_in >= total_in) begin
                value_r <= target_in;
                cnt_r <= 5'h00;
                fin_r <= 1'b0;
            end else begin
                dvd_r <= prod;
                neg_r <= neg;
                rem_r <= 13'h0000;
                quo_r <= 16'h0000;
                cnt_r <= `SGGS_DIV_STEPS;
                fin_r <= 1'b1;
            end
        end else if (cnt_r != 5'h00) begin
            // restoring division, one quotient bit a cycle
            rem_r <= fits ? rem_sh - {1'b0, total_in} : rem_sh;
            quo_r <= {quo_r[14:0], fits};
            dvd_r <= {dvd_r[26:0], 1'b0};
            cnt_r <= cnt_r - 5'h01;
        end else if (fin_r) begin
            value_r <= neg_r ? start_r - quo_r : start_r + quo_r;
            fin_r <= 1'b0;
        end
    end
endmodule : sggs_lerp

/* rtl/sggs_pkg.sv */
package sggs_pkg;
    typedef enum logic [1:0] {
        SGGS_IDLE,
        SGGS_CONFIRM,
        SGGS_BLEND
    } sggs_state_e;
endpackage : sggs_pkg

/* rtl/sggs_switcher.sv */
`timescale 1ns/1ps
`include "sggs_defs.svh"

module sggs_switcher #(
    parameter int MS_CYCLES = `SGGS_MS_CYCLES
) (
    input wire logic CLK_IN, // 100 MHz control clock
    input wire logic RST_B_IN, // async reset, low
    input wire logic PSEL_IN, // apb select
    input wire logic PENABLE_IN, // apb enable
    input wire logic PWRITE_IN, // apb direction
    input wire logic [7:0] PADDR_IN, // apb byte address
    input wire logic [31:0] PWDATA_IN, // apb write data
    output logic [31:0] PRDATA_OUT, // apb read data
    output logic PREADY_OUT, // apb ready
    output logic PSLVERR_OUT, // apb error
    input wire logic GAIN_SEL_IN, // gain-select digital input pin
    input wire logic [15:0] CMD_FREQ_IN, // command pulse rate, 0.1 kHz
    input wire logic [15:0] POS_DEV_IN, // deviation magnitude, pulses
    input wire logic [15:0] MOTOR_SPEED_IN, // speed magnitude, r/min
    output logic [15:0] SPEED_GAIN_OUT, // speed loop gain
    output logic [15:0] SPEED_INTEG_OUT, // speed integral time
    output logic [15:0] TORQUE_FILT_OUT, // torque filter time
    output logic [15:0] POS_GAIN_OUT, // position loop gain
    output logic GROUP_OUT, // active group, 1 = B
    output logic BLENDING_OUT // blend in progress
);
    ////////////////////////////////////////////////////////////////
    logic [2:0] gain_switch_mode_r;
    logic [14:0] gain_switch_level_r;
    logic [14:0] gain_switch_hysteresis_r;
    logic [11:0] gain_switch_confirm_delay_r;
    logic [11:0] gain_blend_time_r;
    logic [15:0] gain_a_r [0:3];
    logic [15:0] gain_b_r [0:3];
    logic [31:0] prdata_r;
    logic gsel_m_r;
    logic gsel_s_r;
    logic lvl_hi_r;
    logic lvl_hi_nxt;
    logic group_r;
    logic group_nxt;
    logic [11:0] cnt_r;
    logic [11:0] cnt_nxt;
    logic [11:0] elapsed_r;
    logic [11:0] elapsed_nxt;
    logic [16:0] tick_cnt_r;
    logic tick_r;
    logic go_r;
    sggs_pkg::sggs_state_e state_r;
    sggs_pkg::sggs_state_e state_nxt;
    logic [31:0] rdata;
    logic hit;
    logic [15:0] gain_now [0:3];
    logic [15:0] target [0:3];

    ////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, read data latched in setup
    wire setup = PSEL_IN && !PENABLE_IN;
    wire wr = PSEL_IN && PENABLE_IN && PWRITE_IN && hit;
    wire sel_mode = PADDR_IN == `SGGS_OFS_MODE;
    wire sel_level = PADDR_IN == `SGGS_OFS_LEVEL;
    wire sel_hyst = PADDR_IN == `SGGS_OFS_HYST;
    wire sel_delay = PADDR_IN == `SGGS_OFS_DELAY;
    wire sel_blend = PADDR_IN == `SGGS_OFS_BLEND;
    wire sel_stat = PADDR_IN == `SGGS_OFS_STATUS;
    wire in_a = PADDR_IN >= `SGGS_OFS_GAIN_A && PADDR_IN < `SGGS_OFS_GAIN_B;
    wire in_b = PADDR_IN >= `SGGS_OFS_GAIN_B && PADDR_IN < `SGGS_OFS_STATUS;
    wire aligned = PADDR_IN[1:0] == 2'h0;
    wire [1:0] idx_a = 2'((PADDR_IN - `SGGS_OFS_GAIN_A) >> 2);
    wire [1:0] idx_b = 2'((PADDR_IN - `SGGS_OFS_GAIN_B) >> 2);
    wire [2:0] status = {state_r == sggs_pkg::SGGS_CONFIRM,
                         state_r == sggs_pkg::SGGS_BLEND, group_r};

    always_comb begin
        rdata = 32'h00000000;
        hit = aligned;
        if (!aligned) begin
            hit = 1'b0;
        end else if (sel_mode) begin
            rdata = {29'h0, gain_switch_mode_r};
        end else if (sel_level) begin
            rdata = {17'h0, gain_switch_level_r};
        end else if (sel_hyst) begin
            rdata = {17'h0, gain_switch_hysteresis_r};
        end else if (sel_delay) begin
            rdata = {20'h0, gain_switch_confirm_delay_r};
        end else if (sel_blend) begin
            rdata = {20'h0, gain_blend_time_r};
        end else if (in_a) begin
            rdata = {16'h0, gain_a_r[idx_a]};
        end else if (in_b) begin
            rdata = {16'h0, gain_b_r[idx_b]};
        end else if (sel_stat) begin
            rdata = {29'h0, status};
        end else begin
            hit = 1'b0;
        end
    end

    assign PREADY_OUT = 1'b1;
    assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;
    assign PRDATA_OUT = prdata_r;

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            prdata_r <= 32'h00000000;
        end else if (setup) begin
            prdata_r <= rdata;
        end
    end

    // status is read only; writes there are accepted and dropped
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            gain_switch_mode_r <= `SGGS_MODE_DEF;
            gain_switch_level_r <= `SGGS_LEVEL_DEF;
            gain_switch_hysteresis_r <= `SGGS_HYST_DEF;
            gain_switch_confirm_delay_r <= `SGGS_DELAY_DEF;
            gain_blend_time_r <= `SGGS_BLEND_DEF;
            for (int i = 0; i < `SGGS_NGAIN; i++) begin
                gain_a_r[i] <= `SGGS_GAIN_A_DEF;
                gain_b_r[i] <= `SGGS_GAIN_B_DEF;
            end
        end else if (wr) begin
            if (sel_mode) begin
                gain_switch_mode_r <= PWDATA_IN[2:0];
            end else if (sel_level) begin
                gain_switch_level_r <= PWDATA_IN[14:0];
            end else if (sel_hyst) begin
                gain_switch_hysteresis_r <= PWDATA_IN[14:0];
            end else if (sel_delay) begin
                gain_switch_confirm_delay_r <= PWDATA_IN[11:0];
            end else if (sel_blend) begin
                gain_blend_time_r <= PWDATA_IN[11:0];
            end else if (in_a) begin
                gain_a_r[idx_a] <= PWDATA_IN[15:0];
            end else if (in_b) begin
                gain_b_r[idx_b] <= PWDATA_IN[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // pin synchroniser and millisecond tick
    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            gsel_m_r <= 1'b0;
            gsel_s_r <= 1'b0;
        end else begin
            gsel_m_r <= GAIN_SEL_IN;
            gsel_s_r <= gsel_m_r;
        end
    end

    wire tick_wrap = tick_cnt_r == 17'(MS_CYCLES - 1);

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            tick_cnt_r <= 17'h00000;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_wrap ? 17'h00000 : tick_cnt_r + 17'h00001;
            tick_r <= tick_wrap;
        end
    end

    ////////////////////////////////////////////////////////////////
    // level comparison with hysteresis
    wire mode_lvl = gain_switch_mode_r == `SGGS_MODE_FREQ
                 || gain_switch_mode_r == `SGGS_MODE_DEV
                 || gain_switch_mode_r == `SGGS_MODE_SPEED;
    wire [15:0] qty = gain_switch_mode_r == `SGGS_MODE_FREQ ? CMD_FREQ_IN
                    : gain_switch_mode_r == `SGGS_MODE_DEV ? POS_DEV_IN
                    : MOTOR_SPEED_IN;
    wire above = {1'b0, qty} > {2'b0, gain_switch_level_r};
    // sum form avoids underflow when hysteresis exceeds level
    wire below = {1'b0, qty} + {2'b0, gain_switch_hysteresis_r}
               < {2'b0, gain_switch_level_r};

    always_comb begin
        lvl_hi_nxt = lvl_hi_r;
        if (!mode_lvl) begin
            lvl_hi_nxt = 1'b0;
        end else if (above) begin
            lvl_hi_nxt = 1'b1;
        end else if (below) begin
            lvl_hi_nxt = 1'b0;
        end
    end

    // undefined mode codes behave as fixed group A
    wire want = gain_switch_mode_r == `SGGS_MODE_FIX_B ? 1'b1
              : gain_switch_mode_r == `SGGS_MODE_DI ? gsel_s_r
              : mode_lvl ? lvl_hi_r
              : 1'b0;

    ////////////////////////////////////////////////////////////////
    // confirm and blend sequencing
    wire confirmed = cnt_r >= gain_switch_confirm_delay_r;
    wire last_ms = elapsed_r + 12'h001 >= gain_blend_time_r;

    always_comb begin
        state_nxt = state_r;
        group_nxt = group_r;
        cnt_nxt = cnt_r;
        elapsed_nxt = elapsed_r;
        case (state_r)
            sggs_pkg::SGGS_IDLE: begin
                cnt_nxt = 12'h000;
                if (want != group_r) begin
                    state_nxt = sggs_pkg::SGGS_CONFIRM;
                end
            end
            sggs_pkg::SGGS_CONFIRM: begin
                if (want == group_r) begin
                    state_nxt = sggs_pkg::SGGS_IDLE;
                    cnt_nxt = 12'h000;
                end else if (confirmed) begin
                    group_nxt = want;
                    elapsed_nxt = 12'h000;
                    cnt_nxt = 12'h000;
                    state_nxt = gain_blend_time_r == 12'h000 ? sggs_pkg::SGGS_IDLE
                                                             : sggs_pkg::SGGS_BLEND;
                end else if (tick_r) begin
                    cnt_nxt = cnt_r + 12'h001;
                end
            end
            sggs_pkg::SGGS_BLEND: begin
                if (tick_r) begin
                    elapsed_nxt = elapsed_r + 12'h001;
                    if (last_ms) begin
                        state_nxt = sggs_pkg::SGGS_IDLE;
                    end
                end
            end
            default: begin
                state_nxt = sggs_pkg::SGGS_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            state_r <= sggs_pkg::SGGS_IDLE;
            group_r <= 1'b0;
            cnt_r <= 12'h000;
            elapsed_r <= 12'h000;
            lvl_hi_r <= 1'b0;
            go_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            group_r <= group_nxt;
            cnt_r <= cnt_nxt;
            elapsed_r <= elapsed_nxt;
            lvl_hi_r <= lvl_hi_nxt;
            go_r <= tick_r && state_r == sggs_pkg::SGGS_BLEND;
        end
    end

    ////////////////////////////////////////////////////////////////
    // one interpolator per gain, all sharing the same timing
    wire blending = state_r == sggs_pkg::SGGS_BLEND;
    wire switch_now = group_nxt != group_r;

    for (genvar g = 0; g < `SGGS_NGAIN; g++) begin : g_gain
        assign target[g] = group_r ? gain_b_r[g] : gain_a_r[g];
        sggs_lerp u_lerp (
            .clk_in(CLK_IN),
            .rst_b_in(RST_B_IN),
            .hold_in(!blending),
            .load_in(switch_now),
            .go_in(go_r),
            .target_in(target[g]),
            .elapsed_in(elapsed_r),
            .total_in(gain_blend_time_r),
            .value_out(gain_now[g])
        );
    end

    assign SPEED_GAIN_OUT = gain_now[0];
    assign SPEED_INTEG_OUT = gain_now[1];
    assign TORQUE_FILT_OUT = gain_now[2];
    assign POS_GAIN_OUT = gain_now[3];
    assign GROUP_OUT = group_r;
    assign BLENDING_OUT = blending;

    ////////////////////////////////////////////////////////////////
    a_mode_fixed: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        gain_switch_mode_r == `SGGS_MODE_FIX_A |-> !want)
        else $error("fixed mode A asks for group B");

    a_di_follows: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        gain_switch_mode_r == `SGGS_MODE_DI |-> want == $past(GAIN_SEL_IN, 2))
        else $error("mode 2 does not follow the select input");

    a_level_above: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        mode_lvl && $stable(gain_switch_mode_r) && above |=> lvl_hi_r)
        else $error("level exceeded without asking for group B");

    a_gains_settled: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        !blending && !$past(blending) && $stable(group_r) && !$past(wr) && $past(RST_B_IN)
        |-> SPEED_GAIN_OUT == target[0] && POS_GAIN_OUT == target[3])
        else $error("gains not on the active group");

    a_level_default: assert property (
        @(posedge CLK_IN)
        $rose(RST_B_IN) |-> gain_switch_level_r == `SGGS_LEVEL_DEF
                         && gain_switch_hysteresis_r == `SGGS_HYST_DEF)
        else $error("level defaults wrong after reset");

    a_hyst_band: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        mode_lvl && lvl_hi_r && !below |=> lvl_hi_r)
        else $error("group B dropped inside hysteresis band");

    a_switch_delay: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        $changed(group_r) |-> $past(confirmed)
                            && $past(state_r) == sggs_pkg::SGGS_CONFIRM)
        else $error("group changed before confirm delay");

    a_cancel_lapse: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        state_r == sggs_pkg::SGGS_CONFIRM && want == group_r
        |=> state_r == sggs_pkg::SGGS_IDLE && cnt_r == 12'h000 && $stable(group_r))
        else $error("lapsed condition did not cancel");

    a_blend_start: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        switch_now && gain_blend_time_r != 12'h000 |=> blending && elapsed_r == 12'h000)
        else $error("change did not start a blend");

    a_return_low: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        $fell(lvl_hi_r) && $past(mode_lvl) |-> $past(below))
        else $error("returned to group A above level minus hysteresis");

    a_blend_lands: assert property (
        @(posedge CLK_IN) disable iff (!RST_B_IN)
        $fell(blending) ##1 !blending && !$past(wr)
        |-> TORQUE_FILT_OUT == target[2] && SPEED_INTEG_OUT == target[1])
        else $error("blend did not end on target");
endmodule : sggs_switcher

/* sim/servo_gain_group_switcher_test.sv */
`timescale 1ns/1ps
`include "sggs_defs.svh"

module servo_gain_group_switcher_test;
    localparam int MS = 40;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic gain_sel = 1'b0;
    logic [1:0] sel = 2'h3;
    logic [15:0] qty = 16'h0000;
    logic [15:0] freq, dev, spd, g_spd, g_int, g_trq, g_pos;
    logic grp, blending;
    int mismatches = 0;
    int checked = 0;

    always #5 clk = ~clk;

    sggs_loops_model u_loops (.clk_in(clk), .sel_in(sel), .qty_in(qty),
        .cmd_freq_out(freq), .pos_dev_out(dev), .speed_out(spd));

    sggs_switcher #(.MS_CYCLES(MS)) u_dut (.CLK_IN(clk), .RST_B_IN(rst_b),
        .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .GAIN_SEL_IN(gain_sel), .CMD_FREQ_IN(freq),
        .POS_DEV_IN(dev), .MOTOR_SPEED_IN(spd), .SPEED_GAIN_OUT(g_spd),
        .SPEED_INTEG_OUT(g_int), .TORQUE_FILT_OUT(g_trq), .POS_GAIN_OUT(g_pos),
        .GROUP_OUT(grp), .BLENDING_OUT(blending));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle budget here: a slave that never answers is caught by the watchdog
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, wd, rd, err);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h0, rd, err);
        chk(what, rd, exp);
        chk("pslverr", {31'h0, err}, 32'h0);
    endtask : rd_chk

    // bounded wait, then the group and all four gains must agree with it
    task automatic wait_grp(input logic exp, input int limit);
        int n;
        logic [15:0] g;
        n = 0;
        while (grp !== exp && n < limit) begin
            @(posedge clk);
            n++;
        end
        repeat (4) @(posedge clk);
        #1;
        g = exp ? `SGGS_GAIN_B_DEF : `SGGS_GAIN_A_DEF;
        chk("group", {31'h0, grp}, {31'h0, exp});
        chk("gains", {g_spd, g_int}, {g, g});
        chk("gains", {g_trq, g_pos}, {g, g});
        // back onto an edge so callers drive inputs there
        @(posedge clk);
    endtask : wait_grp

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_defaults;
        logic [31:0] rd;
        logic err;
        wait_grp(1'b0, 5);
        rd_chk("mode", `SGGS_OFS_MODE, 32'h0);
        rd_chk("level", `SGGS_OFS_LEVEL, 32'h64);
        rd_chk("hyst", `SGGS_OFS_HYST, 32'h5);
        rd_chk("delay", `SGGS_OFS_DELAY, 32'h5);
        rd_chk("blend", `SGGS_OFS_BLEND, 32'h5);
        apb(1'b0, 8'h38, 32'h0, rd, err);
        chk("unmapped err", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        wr(`SGGS_OFS_LEVEL, 32'h7FFF);
        rd_chk("level max", `SGGS_OFS_LEVEL, 32'h7FFF);
        wr(`SGGS_OFS_LEVEL, 32'h64);
    endtask : t_defaults

    task automatic t_fixed;
        wr(`SGGS_OFS_DELAY, 32'h0);
        wr(`SGGS_OFS_BLEND, 32'h0);
        wr(`SGGS_OFS_MODE, 32'h1);
        wait_grp(1'b1, 20);
        rd_chk("status", `SGGS_OFS_STATUS, 32'h1);
        // undefined code 7 must fall back to group A
        wr(`SGGS_OFS_MODE, 32'h7);
        wait_grp(1'b0, 20);
        wr(`SGGS_OFS_MODE, 32'h0);
        wait_grp(1'b0, 20);
    endtask : t_fixed

    // a 1 ms hold cancels; a steady input switches after 3 ms; off returns to A
    task automatic t_input;
        wr(`SGGS_OFS_DELAY, 32'h3);
        wr(`SGGS_OFS_MODE, 32'h2);
        gain_sel <= 1'b1;
        repeat (MS) @(posedge clk);
        gain_sel <= 1'b0;
        wait_grp(1'b0, 5 * MS);
        gain_sel <= 1'b1;
        repeat (3 * MS / 2) @(posedge clk);
        chk("early group", {31'h0, grp}, 32'h0);
        rd_chk("pending", `SGGS_OFS_STATUS, 32'h4);
        wait_grp(1'b1, 4 * MS);
        gain_sel <= 1'b0;
        wait_grp(1'b0, 5 * MS);
        wr(`SGGS_OFS_DELAY, 32'h0);
    endtask : t_input

    task automatic t_level(input logic [2:0] mode);
        // park in mode 0 first: swapping channels under a level mode latches a false high
        wr(`SGGS_OFS_MODE, 32'h0);
        sel <= mode[1:0] - 2'h3;
        qty <= 16'd100;
        wr(`SGGS_OFS_MODE, {29'h0, mode});
        wait_grp(1'b0, 20);
        qty <= 16'd101;
        wait_grp(1'b1, 20);
        qty <= 16'd95;
        wait_grp(1'b1, 20);
        qty <= 16'd94;
        wait_grp(1'b0, 20);
    endtask : t_level

    // every sample mid-blend lies on the 25-step line from 0x64 to 0xC8
    task automatic t_blend;
        int n;
        bit mid;
        n = 0;
        mid = 0;
        wr(`SGGS_OFS_BLEND, 32'h4);
        wr(`SGGS_OFS_MODE, 32'h1);
        while (blending !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (blending === 1'b1 && n < 6 * MS) begin
            @(posedge clk);
            n++;
            if (g_spd === 16'h0096) mid = 1;
            chk("even", {g_int, g_trq}, {g_spd, g_spd});
            chk("even", {16'h0000, g_pos}, {16'h0000, g_spd});
            chk("step", ((g_spd - 16'd100) % 25 == 0 && g_spd <= 16'd200), 1);
        end
        chk("midpoint", {31'h0, mid}, 32'h1);
        chk("length", (n >= 3 * MS && n <= 4 * MS + 5), 1);
        wait_grp(1'b1, 5);
    endtask : t_blend

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_defaults();
        t_fixed();
        t_input();
        for (int m = 3; m <= 5; m++) begin
            t_level(m[2:0]);
        end
        sel <= 2'h3;
        wr(`SGGS_OFS_MODE, 32'h0);
        wait_grp(1'b0, 20);
        t_blend();
        close_out();
    end

    initial begin
        #200000;
        mismatches++;
        close_out();
    end
endmodule : servo_gain_group_switcher_test

/* sim/sggs_loops_model.sv */
`timescale 1ns/1ps

module sggs_loops_model (
    input wire logic clk_in, // control clock
    input wire logic [1:0] sel_in, // channel carrying the test quantity
    input wire logic [15:0] qty_in, // test quantity
    output logic [15:0] cmd_freq_out, // command pulse rate
    output logic [15:0] pos_dev_out, // deviation magnitude
    output logic [15:0] speed_out // speed magnitude
);
    // idle channels sit far above any level, so picking the wrong one flips the group
    always_ff @(posedge clk_in) begin
        cmd_freq_out <= (sel_in == 2'h0) ? qty_in : 16'hFFFF;
        pos_dev_out <= (sel_in == 2'h1) ? qty_in : 16'hFFFF;
        speed_out <= (sel_in == 2'h2) ? qty_in : 16'hFFFF;
    end
endmodule : sggs_loops_model
